// file: src/pcc_map.vh
// register map and constants of the clock output control block
`ifndef PCC_MAP_VH
`define PCC_MAP_VH
`define PCC_IDX_CLK_OUT     16'h4090
`define PCC_IDX_OSC_LOOP    16'h4091
`define PCC_IDX_LOOP_EN     16'h4092
`define PCC_IDX_KEY         16'h40A0
`define PCC_IDX_STATUS      16'h40A1
`define PCC_OE_BIT          15
`define PCC_OD_BIT          13
`define PCC_ONSLOT_LSB      8
`define PCC_SLPSLOT_LSB     4
`define PCC_SRC_BIT         0
`define PCC_INH_BIT         15
`define PCC_XEN_BIT         13
`define PCC_BKUP_BIT        12
`define PCC_AUTO_BIT        7
`define PCC_FREQ_LSB        0
`define PCC_FRAC_BIT        2
`define PCC_LEN_BIT         0
`define PCC_ST_UNLOCK_BIT   0
`define PCC_ST_XVALID_BIT   1
`define PCC_ST_GATE_BIT     2
`define PCC_ST_LRUN_BIT     3
`define PCC_ST_PS_LSB       4
`define PCC_RST_CLK_OUT     16'h0000
`define PCC_RST_OSC_LOOP    16'h1080
`define PCC_RST_LOOP_EN     16'h0000
`define PCC_MASK_CLK_OUT    16'hA771
`define PCC_MASK_OSC_LOOP   16'hB087
`define PCC_MASK_LOOP_EN    16'h0005
`define PCC_KEY_UNLOCK      16'h5A5A
`define PCC_SLOT_FIRST      3'h1
`define PCC_SLOT_LAST       3'h5
`define PCC_SLEEP_BASE      3'h6
`define PCC_PS_OFF          2'h0
`define PCC_PS_ON           2'h1
`define PCC_PS_SLEEP        2'h2
`define PCC_PS_BACKUP       2'h3
`define PCC_RESP_OKAY       2'h0
`define PCC_RESP_SLVERR     2'h2
`endif

// file: src/pcc_slot_seq.v
// timeslot decoder for sequenced enable and disable of the clock output
`timescale 1ns/100ps
`include "pcc_map.vh"
module pcc_slot_seq
(
  // slot codes from the register
  input  wire [2:0] on_slot,
  input  wire [2:0] sleep_slot,
  // sequencer timeslot strobes
  input  wire       start_strobe,
  input  wire [2:0] start_num,
  input  wire       sleep_strobe,
  input  wire [2:0] sleep_num,
  // one-cycle requests
  output wire       set_en,
  output wire       clr_en
);

  // zero means the code asks for no sequenced action
  function [2:0] on_slot_of;
    input [2:0] code;
    begin
      if (code >= `PCC_SLOT_FIRST && code <= `PCC_SLOT_LAST)
        on_slot_of = code;
      else
        on_slot_of = 3'h0;
    end
  endfunction

  function [2:0] sleep_slot_of;
    input [2:0] code;
    begin
      if (code >= `PCC_SLOT_FIRST && code <= `PCC_SLOT_LAST)
        sleep_slot_of = `PCC_SLEEP_BASE - code;
      else
        sleep_slot_of = 3'h0;
    end
  endfunction

  wire [2:0] on_at    = on_slot_of(on_slot);
  wire [2:0] sleep_at = sleep_slot_of(sleep_slot);

  assign set_en = start_strobe && (on_at != 3'h0) &&
                  (start_num == on_at); // RULE_02
  assign clr_en = sleep_strobe && (sleep_at != 3'h0) &&
                  (sleep_num == sleep_at); // RULE_03

endmodule // pcc_slot_seq

// file: src/pcc_clk_gen.v
// glitch-free source gate and pin driver for the clock output
`timescale 1ns/100ps
module pcc_clk_gen
(
  // clock and reset
  input  wire clock,
  input  wire nrst,
  // source selection and state
  input  wire src_sel,
  input  wire loop_level,
  input  wire osc_level,
  input  wire loop_run,
  input  wire osc_run,
  // pin configuration
  input  wire enable,
  input  wire open_drain,
  // pin
  output reg  pin_out,
  output reg  pin_oe,
  output reg  gate
);

  reg  cur_src;
  wire cur_level = cur_src ? osc_level : loop_level;
  wire cur_run   = cur_src ? osc_run : loop_run;
  wire new_level = src_sel ? osc_level : loop_level;
  wire new_run   = src_sel ? osc_run : loop_run;
  wire want      = enable && new_run;
  wire clk_q     = gate && cur_level;

  // gate moves only while the source is low unless the source stops running, which closes it at once
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      gate    <= 1'b0;
      cur_src <= 1'b0;
    end
    else if (gate)
    begin
      if (!cur_run) // RULE_12
        gate <= 1'b0;
      else if (!cur_level && (!want || cur_src != src_sel))
        gate <= 1'b0;
    end
    else
    begin
      cur_src <= src_sel; // RULE_04
      if (want && !new_level) // RULE_12
        gate <= 1'b1;
    end
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else if (open_drain) // RULE_01
    begin
      pin_out <= 1'b0;
      pin_oe  <= enable && !clk_q;
    end
    else
    begin
      pin_out <= clk_q;
      pin_oe  <= enable; // RULE_01
    end
  end

endmodule // pcc_clk_gen

// file: src/pcc_clock_control.v
// clock output control: register file, sequencing and oscillator control
// Functional notes
// (RULE_01) The pin is driven only while the enable bit is set, that bit takes writes only when unlocked, and a drive bit picks CMOS or open drain.
// (RULE_02) Start-up slot codes 1 to 5 enable the output in timeslots 1 to 5, other codes do nothing.
// (RULE_03) Sleep slot codes 1 to 5 disable the output in timeslots 5 down to 1, other codes leave it to the enable bit.
// (RULE_04) The source bit picks the loop output at 0 and the 32.768kHz oscillator at 1.
// (RULE_05) With the inhibit bit set the move to ON is held off until the crystal is valid.
// (RULE_06) With the crystal enable clear the oscillator is off always, else it runs in OFF, ON and SLEEP.
// (RULE_07) The real-time clock stays clocked in BACKUP only with both backup enable and crystal enable set.
// (RULE_08) The auto bit picks automatic or manual loop mode, and the loop output needs the enable bit in either.
// (RULE_09) In automatic mode a 3-bit code picks one of eight preset loop frequencies.
// (RULE_10) The fractional bit picks integer mode at 0 and fractional mode at 1.
// (RULE_11) The loop enable bit is cleared whenever the OFF power state is entered.
// (RULE_12) A source that is not running leaves the output at a static inactive level.
`timescale 1ns/100ps
`include "pcc_map.vh"
module pcc_clock_control
(
  // clock and reset
  input  wire        clock,
  input  wire        nrst,
  // axi4-lite write address
  input  wire [17:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [17:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // power sequencer
  input  wire [1:0]  power_state,
  input  wire        start_slot_strobe,
  input  wire [2:0]  start_slot_num,
  input  wire        sleep_slot_strobe,
  input  wire [2:0]  sleep_slot_num,
  output reg         on_transition_hold,
  // oscillator and loop analog side
  input  wire        crystal_valid_in,
  input  wire        osc_clock_in,
  input  wire        loop_clock_in,
  output reg         crystal_osc_enable,
  output reg         rtc_backup_clock_enable,
  output reg         loop_enable_out,
  output reg         loop_auto_mode_out,
  output reg  [2:0]  loop_auto_frequency_out,
  output reg         loop_fractional_out,
  // clock output pin
  output wire        clock_output_pin_out,
  output wire        clock_output_pin_oe
);

  // register file
  reg  [15:0] clock_output_control;
  reg  [15:0] oscillator_and_loop_mode;
  reg  [15:0] loop_enable_control;
  reg         unlocked;

  // bus state
  reg         aw_held;
  reg         w_held;
  reg  [15:0] aw_idx;
  reg  [15:0] w_data;
  reg  [1:0]  w_strb;

  // pin input synchronisers: loop, osc, crystal valid
  reg  [2:0]  sync1;
  reg  [2:0]  sync2;
  reg  [2:0]  sync3;
  reg  [2:0]  filt;
  reg  [1:0]  prev_state;

  wire        gate;
  wire        set_en;
  wire        clr_en;

  wire        xvalid   = filt[2];
  wire        osc_lvl  = filt[1];
  wire        loop_lvl = filt[0];

  wire        clock_output_enable =
              clock_output_control[`PCC_OE_BIT];
  wire        clock_output_drive_type =
              clock_output_control[`PCC_OD_BIT];
  wire [2:0]  clock_output_on_slot =
              clock_output_control[`PCC_ONSLOT_LSB+2:`PCC_ONSLOT_LSB];
  wire [2:0]  clock_output_sleep_slot =
              clock_output_control[`PCC_SLPSLOT_LSB+2:`PCC_SLPSLOT_LSB];
  wire        clock_output_source =
              clock_output_control[`PCC_SRC_BIT];
  wire        crystal_startup_inhibit =
              oscillator_and_loop_mode[`PCC_INH_BIT];
  wire        crystal_enable =
              oscillator_and_loop_mode[`PCC_XEN_BIT];
  wire        crystal_backup_enable =
              oscillator_and_loop_mode[`PCC_BKUP_BIT];
  wire        loop_auto_mode =
              oscillator_and_loop_mode[`PCC_AUTO_BIT];
  wire [2:0]  loop_auto_frequency =
              oscillator_and_loop_mode[`PCC_FREQ_LSB+2:`PCC_FREQ_LSB];
  wire        loop_fractional_enable =
              loop_enable_control[`PCC_FRAC_BIT];
  wire        loop_enable =
              loop_enable_control[`PCC_LEN_BIT];

  wire        osc_run  = crystal_enable && xvalid;
  wire        loop_run = loop_enable; // RULE_08
  wire        off_entry = (power_state == `PCC_PS_OFF) &&
                          (prev_state != `PCC_PS_OFF);

  // byte-lane merge of a write into a register under its writable mask
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nval;
    input [1:0]  strb;
    input [15:0] mask;
    reg   [15:0] lanes;
    begin
      lanes = {strb[1] ? nval[15:8] : old[15:8],
               strb[0] ? nval[7:0] : old[7:0]};
      merge = (lanes & mask) | (old & ~mask);
    end
  endfunction

  function mapped;
    input [15:0] idx;
    begin
      mapped = (idx == `PCC_IDX_CLK_OUT) ||
               (idx == `PCC_IDX_OSC_LOOP) ||
               (idx == `PCC_IDX_LOOP_EN) ||
               (idx == `PCC_IDX_KEY) ||
               (idx == `PCC_IDX_STATUS);
    end
  endfunction

  wire        do_write = aw_held && w_held && !s_axi_bvalid;
  wire        wr_clk   = do_write && (aw_idx == `PCC_IDX_CLK_OUT);
  wire        wr_osc   = do_write && (aw_idx == `PCC_IDX_OSC_LOOP);
  wire        wr_loop  = do_write && (aw_idx == `PCC_IDX_LOOP_EN);
  wire        wr_key   = do_write && (aw_idx == `PCC_IDX_KEY);

  // the enable bit is masked out while the key is locked
  wire [15:0] clk_mask = unlocked ? `PCC_MASK_CLK_OUT :
              (`PCC_MASK_CLK_OUT & ~(16'h0001 << `PCC_OE_BIT)); // RULE_01

  reg  [15:0] next_clock_output_control;
  reg  [15:0] next_loop_enable_control;

  always @*
  begin
    next_clock_output_control = clock_output_control;
    if (wr_clk)
      next_clock_output_control = merge(clock_output_control, w_data,
                                        w_strb, clk_mask);
    // sequenced set wins over a software clear in the same cycle
    if (clr_en)
      next_clock_output_control[`PCC_OE_BIT] = 1'b0; // RULE_03
    if (set_en)
      next_clock_output_control[`PCC_OE_BIT] = 1'b1; // RULE_02
  end

  always @*
  begin
    next_loop_enable_control = loop_enable_control;
    if (wr_loop)
      next_loop_enable_control = merge(loop_enable_control, w_data,
                                       w_strb, `PCC_MASK_LOOP_EN);
    if (off_entry)
      next_loop_enable_control[`PCC_LEN_BIT] = 1'b0; // RULE_11
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      clock_output_control     <= `PCC_RST_CLK_OUT;
      oscillator_and_loop_mode <= `PCC_RST_OSC_LOOP;
      loop_enable_control      <= `PCC_RST_LOOP_EN;
      unlocked                 <= 1'b0;
      prev_state               <= `PCC_PS_OFF;
    end
    else
    begin
      clock_output_control <= next_clock_output_control;
      loop_enable_control  <= next_loop_enable_control;
      prev_state           <= power_state;
      if (wr_osc)
        oscillator_and_loop_mode <= merge(oscillator_and_loop_mode,
                                          w_data, w_strb,
                                          `PCC_MASK_OSC_LOOP);
      // any key register write other than the full key locks again
      if (wr_key)
        unlocked <= (w_strb == 2'h3) &&
                    (w_data == `PCC_KEY_UNLOCK); // RULE_01
    end
  end

  // write channels are taken independently, answered once both are in
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCC_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 16'h0000;
      w_data        <= 16'h0000;
      w_strb        <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held       <= 1'b1;
        aw_idx        <= s_axi_awaddr[17:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata[15:0];
        w_strb       <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_idx) ? `PCC_RESP_OKAY :
                        `PCC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  reg  [15:0] rd_val;

  always @*
  begin
    rd_val = 16'h0000;
    case (s_axi_araddr[17:2])
      `PCC_IDX_CLK_OUT:  rd_val = clock_output_control;
      `PCC_IDX_OSC_LOOP: rd_val = oscillator_and_loop_mode;
      `PCC_IDX_LOOP_EN:  rd_val = loop_enable_control;
      `PCC_IDX_STATUS:
      begin
        rd_val[`PCC_ST_UNLOCK_BIT] = unlocked;
        rd_val[`PCC_ST_XVALID_BIT] = xvalid;
        rd_val[`PCC_ST_GATE_BIT]   = gate;
        rd_val[`PCC_ST_LRUN_BIT]   = loop_run;
        rd_val[`PCC_ST_PS_LSB+1:`PCC_ST_PS_LSB] = power_state;
      end
      default:           rd_val = 16'h0000;
    endcase
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PCC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_val};
      s_axi_rresp   <= mapped(s_axi_araddr[17:2]) ? `PCC_RESP_OKAY :
                       `PCC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // a level counts once the second and third stages agree
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      filt  <= 3'h0;
    end
    else
    begin
      sync1 <= {crystal_valid_in, osc_clock_in, loop_clock_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (sync2 & sync3) | (filt & (sync2 | sync3));
    end
  end

  // analog controls are registered so the pins never see decode glitches
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      on_transition_hold      <= 1'b0;
      crystal_osc_enable      <= 1'b0;
      rtc_backup_clock_enable <= 1'b0;
      loop_enable_out         <= 1'b0;
      loop_auto_mode_out      <= 1'b1;
      loop_auto_frequency_out <= 3'h0;
      loop_fractional_out     <= 1'b0;
    end
    else
    begin
      on_transition_hold <= crystal_startup_inhibit && !xvalid; // RULE_05
      crystal_osc_enable <= crystal_enable &&
                            ((power_state != `PCC_PS_BACKUP) ||
                             crystal_backup_enable); // RULE_06
      rtc_backup_clock_enable <= crystal_enable &&
                                 crystal_backup_enable; // RULE_07
      loop_enable_out         <= loop_enable; // RULE_08
      loop_auto_mode_out      <= loop_auto_mode; // RULE_08
      loop_auto_frequency_out <= loop_auto_frequency; // RULE_09
      loop_fractional_out     <= loop_fractional_enable; // RULE_10
    end
  end

  pcc_slot_seq u_slot
  (
    .on_slot      (clock_output_on_slot),
    .sleep_slot   (clock_output_sleep_slot),
    .start_strobe (start_slot_strobe),
    .start_num    (start_slot_num),
    .sleep_strobe (sleep_slot_strobe),
    .sleep_num    (sleep_slot_num),
    .set_en       (set_en),
    .clr_en       (clr_en)
  );

  pcc_clk_gen u_gen
  (
    .clock      (clock),
    .nrst       (nrst),
    .src_sel    (clock_output_source),
    .loop_level (loop_lvl),
    .osc_level  (osc_lvl),
    .loop_run   (loop_run),
    .osc_run    (osc_run),
    .enable     (clock_output_enable),
    .open_drain (clock_output_drive_type),
    .pin_out    (clock_output_pin_out),
    .pin_oe     (clock_output_pin_oe),
    .gate       (gate)
  );

endmodule // pcc_clock_control

// file: verification/pcc_clk_sink.sv
// clock receiver on the far side of the output pin, counts delivered edges
`timescale 1ns/100ps
module pcc_clk_sink
(
  // pin
  input  wire        pin_out,
  input  wire        pin_oe,
  // edge counter
  input  wire        clr,
  output reg  [15:0] edges,
  output wire        level
);
  // board pull-up holds an undriven line high, which open drain relies on
  assign level = pin_oe ? pin_out : 1'b1;

  always @(posedge level or posedge clr)
  begin
    if (clr)
      edges <= 16'h0000;
    else
      edges <= edges + 16'h0001;
  end
endmodule // pcc_clk_sink

// file: verification/pcc_clock_control_sva.sv
// port assertions of the clock output control block
`timescale 1ns/100ps
module pcc_chk
(
  // clock and reset
  input wire        clock,
  input wire        nrst,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // power and clocks
  input wire [1:0]  power_state,
  input wire        crystal_osc_enable,
  input wire        rtc_backup_clock_enable,
  input wire        loop_enable_out,
  input wire        clock_output_pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_b_answers: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  a_r_answers: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("no rvalid");
  a_w_ready_back: assert property (s_axi_bvalid && s_axi_bready
    |=> s_axi_awready && s_axi_wready) else $error("write side stuck");
  a_r_ready_back: assert property (s_axi_rvalid && s_axi_rready
    |=> s_axi_arready && !s_axi_rvalid) else $error("read side stuck");
  a_rdata_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper rdata set");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0000_0000) else $error("error read has data");
  a_rtc_needs_xtal: assert property (
    rtc_backup_clock_enable |-> crystal_osc_enable)
    else $error("rtc kept without crystal");
  a_off_clears_loop: assert property (
    power_state == 2'h0 && $past(power_state) != 2'h0
    |-> ##[1:3] !loop_enable_out) else $error("loop kept at off entry");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($rose(clock_output_pin_oe));
endmodule // pcc_chk

bind pcc_clock_control pcc_chk u_chk
(
  .clock(clock), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .power_state(power_state),
  .crystal_osc_enable(crystal_osc_enable),
  .rtc_backup_clock_enable(rtc_backup_clock_enable),
  .loop_enable_out(loop_enable_out),
  .clock_output_pin_oe(clock_output_pin_oe)
);

// file: verification/test_pmic_clock_output_control.sv
// self-checking bench of the clock output control block
`timescale 1ns/100ps
`include "pcc_map.vh"
module test_pmic_clock_output_control;
  localparam [17:0] A_CLK = {`PCC_IDX_CLK_OUT, 2'b00};
  localparam [17:0] A_OSC = {`PCC_IDX_OSC_LOOP, 2'b00};
  localparam [17:0] A_LEN = {`PCC_IDX_LOOP_EN, 2'b00};
  localparam [17:0] A_KEY = {`PCC_IDX_KEY, 2'b00};
  reg         clock, nrst, awvalid, wvalid, bready, arvalid, rready, clr;
  reg         st_stb, sl_stb, xvalid, osc_in, loop_in;
  reg  [17:0] awaddr, araddr;
  reg  [31:0] wdata, seed;
  reg  [2:0]  st_num, sl_num;
  reg  [1:0]  power_state, rr, br;
  reg  [15:0] rv, d;
  wire        awready, wready, bvalid, arready, rvalid, hold, xen, rtc;
  wire        len, lauto, lfrac, pin_out, pin_oe, level;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  lfreq;
  wire [15:0] edges;
  integer     i, c, n, cyc, n_mismatch, samples_checked;

  pcc_clock_control u_dut
  (
    .clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_state(power_state),
    .start_slot_strobe(st_stb), .start_slot_num(st_num),
    .sleep_slot_strobe(sl_stb), .sleep_slot_num(sl_num),
    .on_transition_hold(hold), .crystal_valid_in(xvalid),
    .osc_clock_in(osc_in), .loop_clock_in(loop_in),
    .crystal_osc_enable(xen), .rtc_backup_clock_enable(rtc),
    .loop_enable_out(len), .loop_auto_mode_out(lauto),
    .loop_auto_frequency_out(lfreq), .loop_fractional_out(lfrac),
    .clock_output_pin_out(pin_out), .clock_output_pin_oe(pin_oe)
  );

  pcc_clk_sink u_sink
  (
    .pin_out(pin_out), .pin_oe(pin_oe), .clr(clr), .edges(edges),
    .level(level)
  );

  always #5 clock = ~clock;

  // sources: loop period 16 cycles, oscillator period 24 cycles
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc % 8 == 0) loop_in <= ~loop_in;
    if (cyc % 12 == 0) osc_in <= ~osc_in;
    if (cyc == 12000)
    begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
  begin
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  end
  endfunction

  function hit(input integer c, input integer n, input up);
    hit = c > 0 && c < 6 && (up ? n == c : n == 6 - c);
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  end
  endtask

  task chk1(input got, input exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  end
  endtask

  task wr(input [17:0] a, input [15:0] v);
    reg done;
  begin
    done = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // a late bready makes the slave hold its answer for a while
    bready <= seed[2];
    while (!done)
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        br = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      else if (bvalid)
        bready <= 1'b1;
    end
    @(posedge clock);
  end
  endtask

  task rd(input [17:0] a);
    reg done;
  begin
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= seed[3];
    while (!done)
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rv = rdata[15:0];
        rr = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
      else if (rvalid)
        rready <= 1'b1;
    end
    @(posedge clock);
  end
  endtask

  task slot(input up, input [2:0] num);
  begin
    if (up) st_num <= num;
    else sl_num <= num;
    st_stb <= up;
    sl_stb <= !up;
    @(posedge clock);
    st_stb <= 1'b0;
    sl_stb <= 1'b0;
    @(posedge clock);
  end
  endtask

  task measure(input [15:0] ctl, input [15:0] len_v, input [15:0] lo,
               input [15:0] hi);
  begin
    wr(A_LEN, len_v);
    wr(A_CLK, ctl);
    repeat (20) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (240) @(posedge clock);
    chk1(edges >= lo && edges <= hi, 1'b1);
    if (ctl[13]) chk1(pin_out, 1'b0);
  end
  endtask

  task give_verdict;
  begin
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  initial
  begin
    {clock, nrst, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {st_stb, sl_stb, xvalid, osc_in, loop_in} = 5'h00;
    {awaddr, araddr, wdata, st_num, sl_num, power_state} = 76'h0;
    clr = 1'b1;
    seed = 32'h0504;
    {cyc, n_mismatch, samples_checked} = 96'h0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(A_CLK);
    chk(rv, 16'h0000);
    rd(A_OSC);
    chk(rv, 16'h1080);
    rd(A_LEN);
    chk(rv, 16'h0000);
    rd(18'h10300);
    chk({14'h0000, rr}, 16'h0002);
    wr(18'h10300, 16'hFFFF);
    chk({14'h0000, br}, 16'h0002);
    // enable bit is key protected, the rest of the word is not
    wr(A_CLK, 16'hFFFF);
    rd(A_CLK);
    chk(rv, 16'h2771);
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = xs(seed);
      d = {seed[15:3], i[2:0]};
      wr(A_OSC, d);
      wr(A_LEN, seed[31:16]);
      repeat (2) @(posedge clock);
      rd(A_OSC);
      chk(rv, d & `PCC_MASK_OSC_LOOP);
      chk({13'h0000, lfreq}, {13'h0000, i[2:0]});
      chk1(lauto, d[7]);
      chk1(len, seed[16]);
      chk1(lfrac, seed[18]);
      chk1(xen, d[13]);
      chk1(rtc, d[13] & d[12]);
      chk1(hold, d[15]);
    end
    xvalid <= 1'b1;
    wr(A_OSC, 16'hB080);
    repeat (8) @(posedge clock);
    chk1(hold, 1'b0);
    wr(A_KEY, `PCC_KEY_UNLOCK);
    wr(A_CLK, 16'h8000);
    rd(A_CLK);
    chk(rv, 16'h8000);
    for (c = 0; c < 8; c = c + 1)
      for (n = 1; n < 6; n = n + 1)
      begin
        wr(A_CLK, {5'h00, c[2:0], 8'h00});
        slot(1'b1, n[2:0]);
        rd(A_CLK);
        chk1(rv[15], hit(c, n, 1'b1));
        wr(A_CLK, {9'h100, c[2:0], 4'h0});
        slot(1'b0, n[2:0]);
        rd(A_CLK);
        chk1(rv[15], !hit(c, n, 1'b0));
      end
    measure(16'h8000, 16'h0001, 16'd14, 16'd16);
    measure(16'h8001, 16'h0001, 16'd9, 16'd11);
    measure(16'hA001, 16'h0000, 16'd9, 16'd11);
    measure(16'h8000, 16'h0000, 16'd0, 16'd0);
    measure(16'h0001, 16'h0001, 16'd0, 16'd0);
    wr(A_LEN, 16'h0005);
    power_state <= `PCC_PS_ON;
    repeat (4) @(posedge clock);
    power_state <= `PCC_PS_OFF;
    repeat (4) @(posedge clock);
    chk1(len, 1'b0);
    rd(A_LEN);
    chk(rv, 16'h0004);
    // backup keeps the crystal only while its backup bit is set
    power_state <= `PCC_PS_BACKUP;
    repeat (2) @(posedge clock);
    chk1(xen, 1'b1);
    wr(A_OSC, 16'h2000);
    chk1(xen, 1'b0);
    chk1(rtc, 1'b0);
    give_verdict;
  end
endmodule // test_pmic_clock_output_control
